// *** rtl/leam_map.vh ***
// constants for the little-endian address modifier
// assumes 32-bit effective addresses and 64-bit double-word memory
`ifndef LEAM_MAP_VH
`define LEAM_MAP_VH
`define LEAM_AW          32
`define LEAM_DW          64
`define LEAM_SZ_W        2
`define LEAM_SZ_1        2'h0
`define LEAM_SZ_2        2'h1
`define LEAM_SZ_4        2'h2
`define LEAM_SZ_8        2'h3
`define LEAM_XOR_8       3'h0
`define LEAM_XOR_4       3'h4
`define LEAM_XOR_2       3'h6
`define LEAM_XOR_1       3'h7
`define LEAM_OP_W        2
`define LEAM_OP_SCALAR   2'h0
`define LEAM_OP_STRING   2'h1
`define LEAM_OP_MULTIPLE 2'h2
`define LEAM_ENDIAN_BIG  1'b0
`define LEAM_ENDIAN_LIT  1'b1
`define LEAM_ST_IDLE     1'b0
`define LEAM_ST_WAIT     1'b1
`endif

// *** rtl/leam_mode.v ***
// endian mode state of the machine state word
// assumes exc_take pulses once per exception entry
`timescale 1ns/10ps
`include "leam_map.vh"
module leam_mode (
  input  wire clk_sys,
  input  wire rst,
  input  wire mode_wr,
  input  wire mode_wr_le,
  input  wire mode_wr_ile,
  input  wire exc_take,
  output reg  current_endian_bit_q,
  output reg  exception_endian_bit_q
);
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      current_endian_bit_q   <= `LEAM_ENDIAN_BIG;
      exception_endian_bit_q <= `LEAM_ENDIAN_BIG;
    end else if (exc_take) begin
      current_endian_bit_q <= exception_endian_bit_q;
    end else if (mode_wr) begin
      current_endian_bit_q   <= mode_wr_le;
      exception_endian_bit_q <= mode_wr_ile;
    end
  end
endmodule

// *** rtl/leam_top.v ***
// little-endian effective address modifier between load/store unit and memory
// assumes one request at a time, held until mem_ack; memory answers with mem_ack
`timescale 1ns/10ps
`include "leam_map.vh"
module leam_top (
  input  wire                    clk_sys,
  input  wire                    rst,
  input  wire                    mode_wr,
  input  wire                    mode_wr_le,
  input  wire                    mode_wr_ile,
  input  wire                    exc_take,
  output wire                    little_endian_mode_bit,
  output wire                    exception_endian_bit,
  input  wire                    req_valid,
  output wire                    req_ready,
  input  wire                    req_write,
  input  wire [`LEAM_SZ_W-1:0]   req_size,
  input  wire [`LEAM_OP_W-1:0]   req_op,
  input  wire [`LEAM_AW-1:0]     effective_address,
  input  wire [`LEAM_DW-1:0]     req_wdata,
  output reg                     rsp_valid,
  output reg                     rsp_align_exc,
  output reg  [`LEAM_DW-1:0]     rsp_rdata,
  output reg                     mem_valid,
  output reg                     mem_write,
  output reg  [`LEAM_SZ_W-1:0]   mem_size,
  output reg  [`LEAM_AW-1:0]     mem_addr,
  output reg  [`LEAM_DW-1:0]     mem_wdata,
  input  wire                    mem_ack,
  input  wire [`LEAM_DW-1:0]     mem_rdata
);
  ////////////////////////////////////////////////////////////////////////////
  // mode state
  wire le_q;
  leam_mode u_mode (
    .clk_sys                (clk_sys),
    .rst                    (rst),
    .mode_wr                (mode_wr),
    .mode_wr_le             (mode_wr_le),
    .mode_wr_ile            (mode_wr_ile),
    .exc_take               (exc_take),
    .current_endian_bit_q   (le_q),
    .exception_endian_bit_q (exception_endian_bit)
  );
  assign little_endian_mode_bit = le_q;

  ////////////////////////////////////////////////////////////////////////////
  // alignment and address modification
  reg [2:0] low_mask;
  reg [2:0] xor_val;
  always @* begin
    case (req_size)
      `LEAM_SZ_1: begin
        low_mask = 3'h0;
        xor_val  = `LEAM_XOR_1;
      end
      `LEAM_SZ_2: begin
        low_mask = 3'h1;
        xor_val  = `LEAM_XOR_2;
      end
      `LEAM_SZ_4: begin
        low_mask = 3'h3;
        xor_val  = `LEAM_XOR_4;
      end
      default: begin
        low_mask = 3'h7;
        xor_val  = `LEAM_XOR_8;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-lane-bit alignment test and address steering
  localparam LOW_W = 3;

  wire [LOW_W-1:0] mis_bit;
  wire [LOW_W-1:0] mod_low;
  wire             le_mode = (le_q == `LEAM_ENDIAN_LIT);

  genvar gi;
  generate
    for (gi = 0; gi < LOW_W; gi = gi + 1) begin : g_low
      // an address bit under the size mask breaks natural alignment
      assign mis_bit[gi] = effective_address[gi] & low_mask[gi];
      // big-endian mode lets the lane bit through untouched
      assign mod_low[gi] = le_mode ?
                           (effective_address[gi] ^ xor_val[gi]) :
                           effective_address[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // exception classification
  wire misaligned = |mis_bit;
  wire op_string  = (req_op == `LEAM_OP_STRING);
  wire op_multi   = (req_op == `LEAM_OP_MULTIPLE);
  wire exc_now    = le_mode &&
                    (misaligned ||
                     op_string ||
                     op_multi);
  wire [`LEAM_AW-1:0] mod_addr = {effective_address[`LEAM_AW-1:LOW_W], mod_low};

  ////////////////////////////////////////////////////////////////////////////
  // request sequencing
  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;

  reg                  st_q;
  reg                  st_d;
  reg                  rsp_valid_d;
  reg                  rsp_align_exc_d;
  reg [`LEAM_DW-1:0]   rsp_rdata_d;
  reg                  mem_valid_d;
  reg                  mem_write_d;
  reg [`LEAM_SZ_W-1:0] mem_size_d;
  reg [`LEAM_AW-1:0]   mem_addr_d;
  reg [`LEAM_DW-1:0]   mem_wdata_d;

  // no new request while memory owes an answer or while the answer is shown
  assign req_ready = (st_q == ST_IDLE) && !rsp_valid;

  wire take = req_valid && req_ready;

  always @* begin
    st_d            = st_q;
    rsp_valid_d     = 1'b0;
    rsp_align_exc_d = rsp_align_exc;
    rsp_rdata_d     = rsp_rdata;
    mem_valid_d     = mem_valid;
    mem_write_d     = mem_write;
    mem_size_d      = mem_size;
    mem_addr_d      = mem_addr;
    mem_wdata_d     = mem_wdata;
    case (st_q)
      ST_IDLE: begin
        if (take) begin
          if (exc_now) begin
            // answered at once, nothing is sent on to memory
            rsp_valid_d     = 1'b1;
            rsp_align_exc_d = 1'b1;
          end else begin
            mem_valid_d = 1'b1;
            mem_write_d = req_write;
            mem_size_d  = req_size;
            mem_addr_d  = mod_addr;
            mem_wdata_d = req_wdata;
            st_d        = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (mem_ack) begin
          mem_valid_d     = 1'b0;
          rsp_valid_d     = 1'b1;
          rsp_align_exc_d = 1'b0;
          rsp_rdata_d     = mem_rdata;
          st_d            = ST_IDLE;
        end
      end
      default: begin
        st_d        = ST_IDLE;
        mem_valid_d = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state and handshake registers
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q      <= ST_IDLE;
      rsp_valid <= 1'b0;
      mem_valid <= 1'b0;
    end else begin
      st_q      <= st_d;
      rsp_valid <= rsp_valid_d;
      mem_valid <= mem_valid_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory request registers
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_write <= 1'b0;
      mem_size  <= `LEAM_SZ_1;
      mem_addr  <= 32'h00000000;
      mem_wdata <= 64'h0000000000000000;
    end else begin
      mem_write <= mem_write_d;
      mem_size  <= mem_size_d;
      mem_addr  <= mem_addr_d;
      mem_wdata <= mem_wdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // response registers
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rsp_align_exc <= 1'b0;
      rsp_rdata     <= 64'h0000000000000000;
    end else begin
      rsp_align_exc <= rsp_align_exc_d;
      rsp_rdata     <= rsp_rdata_d;
    end
  end
endmodule

// *** tb/leam_chk.sv ***
// assertions on the leam_top ports
// assumes one clock domain, bound into every leam_top
`timescale 1ns/10ps
module leam_chk (
  input wire        clk_sys,
  input wire        rst,
  input wire        mode_wr,
  input wire        mode_wr_le,
  input wire        mode_wr_ile,
  input wire        exc_take,
  input wire        req_valid,
  input wire        req_ready,
  input wire        req_write,
  input wire        little_endian_mode_bit,
  input wire        exception_endian_bit,
  input wire        rsp_valid,
  input wire        rsp_align_exc,
  input wire        mem_valid,
  input wire        mem_write,
  input wire        mem_ack,
  input wire [1:0]  req_size,
  input wire [1:0]  req_op,
  input wire [1:0]  mem_size,
  input wire [31:0] effective_address,
  input wire [31:0] mem_addr,
  input wire [63:0] req_wdata,
  input wire [63:0] mem_wdata,
  input wire [63:0] rsp_rdata,
  input wire [63:0] mem_rdata
);
  wire [2:0]  xm = 3'h7 << req_size;
  wire        tk = req_valid & req_ready;
  wire        ex = little_endian_mode_bit & ((|(effective_address[2:0] & ~xm)) |
                   (req_op == 2'h1) | (req_op == 2'h2));
  wire [31:0] em = effective_address ^ {29'h0, xm & {3{little_endian_mode_bit}}};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_addr_mod: assert property (
    tk && !ex |=> mem_valid && mem_addr == $past(em)) else $error("address wrong");
  a_exc_raise: assert property (
    tk && ex |=> rsp_valid && rsp_align_exc) else $error("no exception");
  a_exc_quiet: assert property (
    tk && ex |=> !mem_valid [*2]) else $error("excepting access reached memory");
  a_size_keep: assert property (
    tk && !ex |=> mem_size == $past(req_size) && mem_write == $past(req_write))
    else $error("size or direction wrong");
  a_wdata_keep: assert property (
    tk && !ex |=> mem_wdata == $past(req_wdata)) else $error("store data changed");
  a_rdata_keep: assert property (
    mem_valid && mem_ack |=> rsp_valid && !rsp_align_exc && rsp_rdata == $past(mem_rdata))
    else $error("load data changed");
  a_exc_entry: assert property (
    exc_take |=> little_endian_mode_bit == $past(exception_endian_bit)) else $error("entry mode");
  a_mode_write: assert property (
    mode_wr && !exc_take |=> little_endian_mode_bit == $past(mode_wr_le)) else $error("mode");
  a_ile_write: assert property (
    mode_wr && !exc_take |=> exception_endian_bit == $past(mode_wr_ile)) else $error("ile");
  a_reset_big: assert property (
    $fell(rst) |-> !little_endian_mode_bit && !exception_endian_bit) else $error("reset mode");
endmodule
bind leam_top leam_chk u_chk (.*);

// *** tb/leam_mem.sv ***
// behavioural memory on the far side of leam_top
// assumes eight double words, ack after one or four cycles
`timescale 1ns/10ps
module leam_mem (
  input  wire        clk_sys, slow, mem_valid, mem_write,
  input  wire [31:0] mem_addr,
  input  wire [63:0] mem_wdata,
  output reg         mem_ack = 1'b0,
  output reg  [63:0] mem_rdata = 64'h0
);
  reg [63:0] m [0:7];
  reg [1:0]  w = 2'h0;
  always @(posedge clk_sys) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_valid && !mem_ack) begin
      w <= w + 2'h1;
      if (!slow || &w) begin
        mem_ack <= 1'b1;
        w <= 2'h0;
        if (mem_write) m[mem_addr[5:3]] <= mem_wdata;
        else mem_rdata <= m[mem_addr[5:3]];
      end
    end
  end
endmodule

// *** tb/leam_top_bench.sv ***
// bench for leam_top with the memory model
// assumes leam_map.vh on the include path
`timescale 1ns/10ps
module leam_top_bench;
  reg         clk_sys = 0, rst = 1, mode_wr = 0, mode_wr_le = 0, mode_wr_ile = 0, exc_take = 0;
  reg         req_valid = 0, req_write = 0, slow = 0;
  reg  [1:0]  req_size = 0, req_op = 0, s;
  reg  [2:0]  mx;
  reg  [31:0] effective_address = 0;
  reg  [63:0] req_wdata = 0;
  wire        little_endian_mode_bit, exception_endian_bit, req_ready, rsp_valid, rsp_align_exc;
  wire        mem_valid, mem_write, mem_ack;
  wire [1:0]  mem_size;
  wire [31:0] mem_addr;
  wire [63:0] rsp_rdata, mem_wdata, mem_rdata;
  integer     n_mismatch = 0, tests_run = 0;
  always #50 clk_sys = ~clk_sys;
  leam_top DUT (.*);
  leam_mem u_mem (.*);
  task check(input [63:0] v, input [63:0] x);
    begin
      tests_run = tests_run + 1;
      if (v !== x) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, v, x);
      end
    end
  endtask
  task results;
    begin
      $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  task setm(input l, input i, input x);
    begin
      @(negedge clk_sys); mode_wr = 1; mode_wr_le = l; mode_wr_ile = i; exc_take = x;
      @(negedge clk_sys); mode_wr = 0; exc_take = 0;
    end
  endtask
  task acc(input w, input [1:0] z, o, input [31:0] a, input [63:0] d, input e, input [31:0] ma);
    reg [31:0] got;
    reg [1:0]  gs;
    integer    i;
    begin
      @(negedge clk_sys); req_valid = 1; req_write = w; req_size = z; req_op = o;
      effective_address = a; req_wdata = d; got = 0; gs = 0;
      @(negedge clk_sys); req_valid = 0;
      for (i = 0; i < 20 && rsp_valid !== 1'b1; i = i + 1) begin
        if (mem_valid === 1'b1) begin
          got = mem_addr;
          gs  = mem_size;
        end
        @(negedge clk_sys);
      end
      check(rsp_valid, 1);
      check(rsp_align_exc, e);
      check(got, ma);
      if (!e) check(gs, z);
      if (!w && !e) check(rsp_rdata, d);
    end
  endtask
  task t_big;
    begin
      check(little_endian_mode_bit, 0);
      check(exception_endian_bit, 0);
      slow = 1;
      acc(1, 2'h2, 2'h0, 32'h5, 64'h1112131400000000, 0, 32'h5);
      acc(0, 2'h0, 2'h0, 32'h5, 64'h1112131400000000, 0, 32'h5);
      slow = 0;
    end
  endtask
  task t_little;
    begin
      setm(1, 0, 0);
      for (s = 0; s < 3; s = s + 1) begin
        mx = 3'h7 << s;
        acc(1, s, 2'h0, 32'h18, {62'h0, s}, 0, 32'h18 ^ mx);
        acc(0, s, 2'h0, 32'h18, {62'h0, s}, 0, 32'h18 ^ mx);
      end
      acc(1, 2'h3, 2'h0, 32'h20, 64'h2122232425262728, 0, 32'h20);
      acc(0, 2'h3, 2'h0, 32'h20, 64'h2122232425262728, 0, 32'h20);
    end
  endtask
  task t_fault;
    begin
      acc(0, 2'h2, 2'h1, 32'h10, 0, 1, 0);
      acc(1, 2'h2, 2'h2, 32'h10, 0, 1, 0);
      acc(1, 2'h1, 2'h0, 32'h11, 0, 1, 0);
      acc(0, 2'h3, 2'h0, 32'h1C, 0, 1, 0);
    end
  endtask
  task t_exc;
    begin
      setm(0, 1, 0);
      check(little_endian_mode_bit, 0);
      check(exception_endian_bit, 1);
      setm(0, 0, 1);
      check(little_endian_mode_bit, 1);
      check(exception_endian_bit, 1);
    end
  endtask
  initial begin
    repeat (20) @(negedge clk_sys);
    rst = 0;
    t_big;
    t_little;
    t_fault;
    t_exc;
    results;
  end
  initial begin
    #200000;
    n_mismatch = n_mismatch + 1;
    results;
  end
endmodule
